// ===== rate_limiter_pkg.sv
package rate_limiter_pkg;
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          TICK_US         = 125;
    localparam int          TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int          TICK_W          = 14;
    localparam int          ADDR_W          = 8;
    localparam int          LEN_W           = 11;
    localparam int          BYTES_W         = 12;
    localparam int          CREDIT_W        = 14;
    localparam int          NBUCKET         = 8;
    localparam int          NPRI            = 4;
    localparam logic [7:0]  IDX_ACCOUNTING  = 8'h06;
    localparam logic [7:0]  IDX_INGRESS     = 8'h08;
    localparam logic [7:0]  IDX_EGRESS      = 8'h0A;
    localparam logic [7:0]  IDX_QUEUE_CTRL  = 8'h0C;
    localparam logic [7:0]  IDX_STATUS      = 8'h0E;
    localparam logic [7:0]  ADDR_ACCOUNTING = IDX_ACCOUNTING << 2;
    localparam logic [7:0]  ADDR_INGRESS    = IDX_INGRESS << 2;
    localparam logic [7:0]  ADDR_EGRESS     = IDX_EGRESS << 2;
    localparam logic [7:0]  ADDR_QUEUE_CTRL = IDX_QUEUE_CTRL << 2;
    localparam logic [7:0]  ADDR_STATUS     = IDX_STATUS << 2;
    localparam int          PREAMBLE_BIT    = 0;
    localparam int          GAP_BIT         = 1;
    localparam int          MODE_LSB        = 2;
    localparam int          MULTI_Q_BIT     = 0;
    localparam logic [15:0] ACCT_WMASK      = 16'h000F;
    localparam logic [15:0] QCTRL_WMASK     = 16'h0001;
    localparam logic [15:0] RESET_VALUE     = 16'h0000;
    localparam logic [1:0]  MODE_ALL        = 2'h0;
    localparam logic [1:0]  MODE_FLOODED    = 2'h1;
    localparam logic [1:0]  MODE_MULTICAST  = 2'h2;
    localparam logic [1:0]  MODE_BROADCAST  = 2'h3;
    localparam logic [BYTES_W-1:0] GAP_BYTES      = 12'h00C;
    localparam logic [BYTES_W-1:0] PREAMBLE_BYTES = 12'h008;
    localparam logic [3:0]  CODE_UNLIMITED  = 4'h0;
    localparam logic [3:0]  CODE_MAX_10M    = 4'h8;
    localparam logic signed [CREDIT_W-1:0] CREDIT_MAX = 14'sh0FFF;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Bytes of credit added per 125 us tick: 64 Kbps is exactly one byte per tick.
    localparam logic [10:0] RATE_BYTES [16] = '{
        11'h000, 11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040,
        11'h080, 11'h100, 11'h200, 11'h2EE, 11'h3E8, 11'h465, 11'h4E2, 11'h55F
    };
endpackage

// ===== port_rate_limiter.sv
`timescale 1ns/100ps
`default_nettype none
module port_rate_limiter #(
    parameter int TICK_CYCLES = rate_limiter_pkg::TICK_CYCLES
) (
    input  wire logic                                  clk_i,
    input  wire logic                                  sys_rst_i,
    input  wire logic [rate_limiter_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
    input  wire logic                                  s_axi_awvalid_i,
    output logic                                       s_axi_awready_o,
    input  wire logic [31:0]                           s_axi_wdata_i,
    input  wire logic [3:0]                            s_axi_wstrb_i,
    input  wire logic                                  s_axi_wvalid_i,
    output logic                                       s_axi_wready_o,
    output logic [1:0]                                 s_axi_bresp_o,
    output logic                                       s_axi_bvalid_o,
    input  wire logic                                  s_axi_bready_i,
    input  wire logic [rate_limiter_pkg::ADDR_W-1:0]   s_axi_araddr_i,
    input  wire logic                                  s_axi_arvalid_i,
    output logic                                       s_axi_arready_o,
    output logic [31:0]                                s_axi_rdata_o,
    output logic [1:0]                                 s_axi_rresp_o,
    output logic                                       s_axi_rvalid_o,
    input  wire logic                                  s_axi_rready_i,
    input  wire logic                                  speed_10_i,
    input  wire logic                                  ing_valid_i,
    input  wire logic [1:0]                            ing_pri_i,
    input  wire logic [rate_limiter_pkg::LEN_W-1:0]    ing_len_i,
    input  wire logic                                  ing_bcast_i,
    input  wire logic                                  ing_mcast_i,
    input  wire logic                                  ing_flood_i,
    output logic                                       ing_done_o,
    output logic                                       ing_drop_o,
    input  wire logic                                  egr_valid_i,
    input  wire logic [1:0]                            egr_pri_i,
    input  wire logic [rate_limiter_pkg::LEN_W-1:0]    egr_len_i,
    output logic                                       egr_grant_o
);
    logic [15:0]                                acct_reg;
    logic [15:0]                                ingress_reg;
    logic [15:0]                                egress_reg;
    logic [15:0]                                qctrl_reg;
    logic                                       spd_s1_reg;
    logic                                       spd_s2_reg;
    logic                                       spd_s3_reg;
    logic                                       speed10_reg;
    logic [rate_limiter_pkg::TICK_W-1:0]        tick_cnt_reg;
    logic                                       tick;
    logic [rate_limiter_pkg::NBUCKET-1:0]       credit_ok;
    logic [rate_limiter_pkg::NBUCKET-1:0]       limited;
    logic [rate_limiter_pkg::BYTES_W-1:0]       ing_bytes;
    logic [rate_limiter_pkg::BYTES_W-1:0]       egr_bytes;
    logic                                       counted;
    logic                                       ing_take;
    logic [1:0]                                 egr_q;
    logic                                       egr_take;
    logic                                       aw_full_reg;
    logic                                       w_full_reg;
    logic [rate_limiter_pkg::ADDR_W-1:0]        awaddr_reg;
    logic [31:0]                                wdata_reg;
    logic [3:0]                                 wstrb_reg;
    logic                                       do_write;
    logic                                       aw_take;
    logic                                       w_take;
    logic                                       ar_take;
    logic [15:0]                                wr_val;
    logic [31:0]                                rd_val;
    logic                                       rd_hit;

    // The link speed comes from the PHY clock domain; a change is believed once two stages agree.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            spd_s1_reg  <= 1'b0;
            spd_s2_reg  <= 1'b0;
            spd_s3_reg  <= 1'b0;
            speed10_reg <= 1'b0;
        end
        else
        begin
            spd_s1_reg <= speed_10_i;
            spd_s2_reg <= spd_s1_reg;
            spd_s3_reg <= spd_s2_reg;
            if (spd_s2_reg == spd_s3_reg)
                speed10_reg <= spd_s3_reg;
        end
    end

    // A coarse 125 us refill tick keeps the credit adders narrow at the cost of burst granularity.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || tick)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
    assign tick = (tick_cnt_reg == rate_limiter_pkg::TICK_W'(TICK_CYCLES - 1));

    assign ing_bytes = rate_limiter_pkg::BYTES_W'(ing_len_i)
        + (acct_reg[rate_limiter_pkg::GAP_BIT] ? rate_limiter_pkg::GAP_BYTES : '0)
        + (acct_reg[rate_limiter_pkg::PREAMBLE_BIT] ? rate_limiter_pkg::PREAMBLE_BYTES : '0);
    assign egr_bytes = rate_limiter_pkg::BYTES_W'(egr_len_i)
        + (acct_reg[rate_limiter_pkg::GAP_BIT] ? rate_limiter_pkg::GAP_BYTES : '0)
        + (acct_reg[rate_limiter_pkg::PREAMBLE_BIT] ? rate_limiter_pkg::PREAMBLE_BYTES : '0);

    always_comb
    begin
        case (acct_reg[rate_limiter_pkg::MODE_LSB +: 2])
            rate_limiter_pkg::MODE_ALL:       counted = 1'b1;
            rate_limiter_pkg::MODE_FLOODED:   counted = ing_bcast_i | ing_mcast_i | ing_flood_i;
            rate_limiter_pkg::MODE_MULTICAST: counted = ing_bcast_i | ing_mcast_i;
            rate_limiter_pkg::MODE_BROADCAST: counted = ing_bcast_i;
            default:                          counted = 1'b1;
        endcase
    end

    // Buckets 0-3 police ingress priorities 0-3, buckets 4-7 shape egress queues 0-3.
    genvar b;
    generate
        for (b = 0; b < rate_limiter_pkg::NBUCKET; b++)
        begin : bucket
            logic [3:0]                                 raw_code;
            logic [3:0]                                 code;
            logic                                       spend;
            logic signed [rate_limiter_pkg::CREDIT_W-1:0] credit_reg;
            logic signed [rate_limiter_pkg::CREDIT_W-1:0] credit_next;
            if (b < rate_limiter_pkg::NPRI)
            begin : ing
                assign raw_code = ingress_reg[4*b +: 4];
                assign spend    = ing_take && (ing_pri_i == 2'(b));
            end
            else
            begin : egr
                assign raw_code = egress_reg[4*(b-4) +: 4];
                assign spend    = egr_take && (egr_q == 2'(b - 4));
            end
            assign code = (speed10_reg && raw_code > rate_limiter_pkg::CODE_MAX_10M)
                ? rate_limiter_pkg::CODE_UNLIMITED : raw_code;
            assign limited[b] = (code != rate_limiter_pkg::CODE_UNLIMITED);
            assign credit_next = credit_reg
                + (tick ? rate_limiter_pkg::CREDIT_W'(rate_limiter_pkg::RATE_BYTES[code]) : '0)
                - (spend ? rate_limiter_pkg::CREDIT_W'(spend ? (b < 4 ? ing_bytes : egr_bytes)
                    : '0) : '0);
            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i || !limited[b])
                    credit_reg <= rate_limiter_pkg::CREDIT_MAX;
                else if (credit_next > rate_limiter_pkg::CREDIT_MAX)
                    credit_reg <= rate_limiter_pkg::CREDIT_MAX;
                else
                    credit_reg <= credit_next;
            end
            assign credit_ok[b] = !limited[b] || (credit_reg > 0);
        end
    endgenerate

    assign ing_take = ing_valid_i && counted && credit_ok[ing_pri_i];
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ing_done_o <= 1'b0;
            ing_drop_o <= 1'b0;
        end
        else
        begin
            ing_done_o <= ing_valid_i;
            ing_drop_o <= ing_valid_i && counted && !credit_ok[ing_pri_i];
        end
    end

    // Without multiple queues every frame sits in queue 0 and uses its limit.
    assign egr_q    = qctrl_reg[rate_limiter_pkg::MULTI_Q_BIT] ? egr_pri_i : 2'h0;
    assign egr_take = egr_valid_i && !egr_grant_o && credit_ok[4 + egr_q];
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            egr_grant_o <= 1'b0;
        else
            egr_grant_o <= egr_take;
    end

    assign aw_take  = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take   = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_take  = s_axi_arvalid_i && s_axi_arready_o;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
    assign wr_val   = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                       wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_full_reg     <= 1'b0;
            w_full_reg      <= 1'b0;
            awaddr_reg      <= '0;
            wdata_reg       <= '0;
            wstrb_reg       <= '0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_i;
            end
            else if (do_write)
                aw_full_reg <= 1'b0;
            if (w_take)
            begin
                w_full_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_i;
                wstrb_reg  <= s_axi_wstrb_i;
            end
            else if (do_write)
                w_full_reg <= 1'b0;
            s_axi_awready_o <= !aw_full_reg && !aw_take && !s_axi_bvalid_o && !do_write;
            s_axi_wready_o  <= !w_full_reg && !w_take && !s_axi_bvalid_o && !do_write;
        end
    end

    // Bytes left out by the strobes write as zero, since every register is a whole halfword.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            acct_reg    <= rate_limiter_pkg::RESET_VALUE;
            ingress_reg <= rate_limiter_pkg::RESET_VALUE;
            egress_reg  <= rate_limiter_pkg::RESET_VALUE;
            qctrl_reg   <= rate_limiter_pkg::RESET_VALUE;
        end
        else if (do_write)
        begin
            case (awaddr_reg)
                rate_limiter_pkg::ADDR_ACCOUNTING:
                    acct_reg <= wr_val & rate_limiter_pkg::ACCT_WMASK;
                rate_limiter_pkg::ADDR_INGRESS:    ingress_reg <= wr_val;
                rate_limiter_pkg::ADDR_EGRESS:     egress_reg <= wr_val;
                rate_limiter_pkg::ADDR_QUEUE_CTRL:
                    qctrl_reg <= wr_val & rate_limiter_pkg::QCTRL_WMASK;
                default:                           ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= rate_limiter_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_o <= 1'b1;
            case (awaddr_reg)
                rate_limiter_pkg::ADDR_ACCOUNTING, rate_limiter_pkg::ADDR_INGRESS,
                rate_limiter_pkg::ADDR_EGRESS, rate_limiter_pkg::ADDR_QUEUE_CTRL,
                rate_limiter_pkg::ADDR_STATUS:
                    s_axi_bresp_o <= rate_limiter_pkg::RESP_OKAY;
                default:
                    s_axi_bresp_o <= rate_limiter_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
    end

    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr_i)
            rate_limiter_pkg::ADDR_ACCOUNTING: rd_val = {16'h0000, acct_reg};
            rate_limiter_pkg::ADDR_INGRESS:    rd_val = {16'h0000, ingress_reg};
            rate_limiter_pkg::ADDR_EGRESS:     rd_val = {16'h0000, egress_reg};
            rate_limiter_pkg::ADDR_QUEUE_CTRL: rd_val = {16'h0000, qctrl_reg};
            rate_limiter_pkg::ADDR_STATUS:     rd_val = {23'h000000, speed10_reg, ~credit_ok};
            default:
            begin
                rd_val = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= rate_limiter_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready_o <= !ar_take && !s_axi_rvalid_o;
            if (ar_take)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o  <= rd_val;
                s_axi_rresp_o  <= rd_hit ? rate_limiter_pkg::RESP_OKAY
                                         : rate_limiter_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_bcast_mode_pass: assert property (
        ing_valid_i && acct_reg[3:2] == rate_limiter_pkg::MODE_BROADCAST && !ing_bcast_i
        |=> ing_done_o && !ing_drop_o)
        else $error("Non-broadcast frame dropped in broadcast-only mode.");
    a_credit_spend: assert property (
        ing_take && ing_pri_i == 2'h0 && limited[0] && !tick
        |=> bucket[0].credit_reg == $past(bucket[0].credit_reg)
            - rate_limiter_pkg::CREDIT_W'($past(ing_bytes)))
        else $error("Priority 0 credit not reduced by counted bytes.");
    a_exhausted_drop: assert property (
        ing_valid_i && counted && !credit_ok[ing_pri_i] |=> ing_drop_o && ing_done_o)
        else $error("Frame over its ingress rate was not dropped.");
    a_unlimited_pass: assert property (
        ing_valid_i && ingress_reg[4*ing_pri_i +: 4] == 4'h0 |=> !ing_drop_o)
        else $error("Frame with an unlimited code was dropped.");
    a_slow_link_free: assert property (
        ing_valid_i && speed10_reg && ingress_reg[4*ing_pri_i +: 4] > 4'h8 |=> !ing_drop_o)
        else $error("Rate above 10 Mbps enforced on a 10 Mbit/s link.");
    a_egress_hold: assert property (
        egr_valid_i && !egr_grant_o && !credit_ok[4 + egr_q] |=> !egr_grant_o)
        else $error("Egress frame granted without credit.");
    a_single_queue: assert property (
        !qctrl_reg[0] && egr_valid_i && !egr_grant_o && egress_reg[3:0] == 4'h0
        |=> egr_grant_o)
        else $error("Single queue not governed by the priority 0 limit.");
    a_pri1_nibble: assert property (
        qctrl_reg[0] && egr_valid_i && egr_pri_i == 2'h1 && !egr_grant_o
        && egress_reg[7:4] == 4'h0 |=> egr_grant_o)
        else $error("Unlimited priority 1 queue was not granted.");
    a_bresp_holds: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write response withdrawn before it was taken.");

    c_ingress_drop: cover property (ing_drop_o);
    c_egress_stall: cover property (egr_valid_i && !credit_ok[4 + egr_q] ##[1:1000] egr_grant_o);
    c_reg_write: cover property (do_write && awaddr_reg == rate_limiter_pkg::ADDR_INGRESS);
endmodule
`default_nettype wire

// ===== link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        want_i,
    input  wire logic [1:0]  pri_i,
    input  wire logic [10:0] len_i,
    input  wire logic        egr_grant_i,
    output logic             egr_valid_o,
    output logic [1:0]       egr_pri_o,
    output logic [10:0]      egr_len_o,
    output logic [15:0]      grants_o
);
    // An offered frame stays put until granted, even if the bench stops wanting more.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            egr_valid_o <= 1'b0;
            egr_pri_o   <= 2'h0;
            egr_len_o   <= 11'h000;
            grants_o    <= 16'h0000;
        end
        else
        begin
            egr_valid_o <= want_i || (egr_valid_o && !egr_grant_i);
            if (!egr_valid_o || egr_grant_i)
            begin
                egr_pri_o <= pri_i;
                egr_len_o <= len_i;
            end
            if (egr_grant_i)
                grants_o <= grants_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== port_rate_limiter_bench.sv
`timescale 1ns/100ps
`default_nettype none
module port_rate_limiter_bench;
    logic        clk, rst, awv, wv, bready, arv, rready, spd10, iv, ib, im, ifl, want;
    logic        awr, wr, bv, arr, rv, idone, idrop, ev, eg;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, ipri, epri, qpri;
    logic [10:0] ilen, elen, qlen;
    logic [15:0] grants;
    int          bad_count, checks_done;
    localparam logic [2:0] MODEF [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    port_rate_limiter #(.TICK_CYCLES(20)) dut (.clk_i(clk), .sys_rst_i(rst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .speed_10_i(spd10),
        .ing_valid_i(iv), .ing_pri_i(ipri), .ing_len_i(ilen), .ing_bcast_i(ib),
        .ing_mcast_i(im), .ing_flood_i(ifl), .ing_done_o(idone), .ing_drop_o(idrop),
        .egr_valid_i(ev), .egr_pri_i(qpri), .egr_len_i(qlen), .egr_grant_o(eg));
    link_partner_model partner (.clk_i(clk), .sys_rst_i(rst), .want_i(want),
        .pri_i(epri), .len_i(elen), .egr_grant_i(eg), .egr_valid_o(ev),
        .egr_pri_o(qpri), .egr_len_o(qlen), .grants_o(grants));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        while (!bv);
        bready <= 1'b0;
        chk(bresp, r);
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end
        while (!rv);
        rready <= 1'b0;
        chk(rdata, {16'h0000, d});
        chk(rresp, r);
        @(posedge clk);
    endtask
    task automatic frm(input logic [1:0] p, input logic [10:0] l, input logic [2:0] f,
                       input logic d);
        ipri <= p;
        ilen <= l;
        {ib, im, ifl} <= f;
        iv <= 1'b1;
        @(posedge clk);
        iv <= 1'b0;
        @(posedge clk);
        chk(idone, 1'b1);
        chk(idrop, d);
    endtask
    // A new code after code zero restarts the bucket full, so each run starts clean.
    task automatic run(input logic [1:0] p, input logic [3:0] c, input logic [15:0] acct,
                       input int n);
        axw(rate_limiter_pkg::ADDR_INGRESS, 16'h0000, rate_limiter_pkg::RESP_OKAY);
        axw(rate_limiter_pkg::ADDR_INGRESS, {12'h000, c} << (4 * p), 2'h0);
        axw(rate_limiter_pkg::ADDR_ACCOUNTING, acct, rate_limiter_pkg::RESP_OKAY);
        for (int i = 0; i < n; i++)
            frm(p, 11'h3FF, 3'h0, 1'b0);
        frm(p, 11'h3FF, 3'h0, 1'b1);
        frm(p ^ 2'h1, 11'h3FF, 3'h0, 1'b0);
    endtask
    // Queue 1 follows bits 7:4 alone: a full bucket lets exactly three 1500-byte frames go.
    task automatic pri1_shape;
        logic [15:0] start_grants;
        epri <= 2'h1;
        axw(rate_limiter_pkg::ADDR_EGRESS, 16'h0010, 2'h0);
        start_grants = grants;
        want <= 1'b1;
        repeat (300) @(posedge clk);
        want <= 1'b0;
        chk(grants - start_grants, 16'h0003);
    endtask
    initial
    begin
        {rst, awv, wv, bready, arv, rready, spd10, iv, ib, im, ifl, want} = 12'h800;
        {awaddr, araddr, wdata, wstrb, ipri, epri, ilen, elen} = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axr(rate_limiter_pkg::ADDR_ACCOUNTING, 16'h0000, 2'h0);
        axr(rate_limiter_pkg::ADDR_INGRESS, 16'h0000, 2'h0);
        axr(rate_limiter_pkg::ADDR_EGRESS, 16'h0000, 2'h0);
        axw(8'h04, 16'h1234, rate_limiter_pkg::RESP_SLVERR);
        axr(8'h04, 16'h0000, rate_limiter_pkg::RESP_SLVERR);
        axw(rate_limiter_pkg::ADDR_ACCOUNTING, 16'hFFFF, 2'h0);
        axr(rate_limiter_pkg::ADDR_ACCOUNTING, 16'h000F, 2'h0);
        run(2'h0, 4'h1, 16'h0000, 5);
        run(2'h3, 4'h1, 16'h0002, 4);
        run(2'h1, 4'h1, 16'h0001, 4);
        run(2'h0, 4'h9, 16'h0000, 5);
        run(2'h2, 4'h1, 16'h0003, 4);
        for (int m = 3; m >= 0; m--)
        begin
            axw(rate_limiter_pkg::ADDR_ACCOUNTING, 16'(m << 2), 2'h0);
            frm(2'h2, 11'h064, MODEF[m], 1'b1);
            if (m > 0) frm(2'h2, 11'h064, MODEF[m - 1], 1'b0);
        end
        spd10 <= 1'b1;
        axw(rate_limiter_pkg::ADDR_INGRESS, 16'h0000, 2'h0);
        axw(rate_limiter_pkg::ADDR_INGRESS, 16'h0009, 2'h0);
        repeat (7) frm(2'h0, 11'h3FF, 3'h0, 1'b0);
        epri <= 2'h2;
        elen <= 11'h5DC;
        axw(rate_limiter_pkg::ADDR_EGRESS, 16'h0001, 2'h0);
        want <= 1'b1;
        repeat (300) @(posedge clk);
        want <= 1'b0;
        chk(grants, 16'h0003);
        axr(rate_limiter_pkg::ADDR_STATUS, 16'h0110, 2'h0);
        axw(rate_limiter_pkg::ADDR_QUEUE_CTRL, 16'h0001, 2'h0);
        epri <= 2'h1;
        want <= 1'b1;
        repeat (100) @(posedge clk);
        want <= 1'b0;
        chk(grants > 16'h001E, 1'b1);
        pri1_shape();
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
